// File: verilog/ssp_regs.vh
// Register map, field positions, reset values and clock divisors of the serial port.
// Included by the serial port top module only; holds definitions only.
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// Register indices; byte address is four times the index.
`define SSP_IDX_DATA 8'h3C
`define SSP_IDX_CFG 8'h3D
`define SSP_IDX_STS 8'h40
`define SSP_IDX_MSK 8'h41
`define SSP_IDX_PIN 8'h42

// Configure register fields.
`define SSP_CFG_SWAP 7
`define SSP_CFG_LSBF 6
`define SSP_CFG_MODE_HI 5
`define SSP_CFG_MODE_LO 4
`define SSP_CFG_CPOL 3
`define SSP_CFG_CPHA 2
`define SSP_CFG_RATE_HI 1
`define SSP_CFG_RATE_LO 0

// Operating modes.
`define SSP_MODE_OFF 2'h0
`define SSP_MODE_MASTER 2'h1
`define SSP_MODE_SLAVE 2'h2

// Status bits; the mask covers bits 0 and 1 only.
`define SSP_STS_TXE 0
`define SSP_STS_RXF 1
`define SSP_STS_THR_FULL 2
`define SSP_STS_BUSY 3

// Pin control fields: serial use, gpio output, gpio enable, pin readback.
`define SSP_PIN_USE_LO 0
`define SSP_PIN_OUT_LO 4
`define SSP_PIN_OE_LO 8
`define SSP_PIN_IN_LO 12

// Reset values.
`define SSP_RST_DATA 8'h00
`define SSP_RST_CFG 8'h00
`define SSP_RST_PIN 12'h000

// Processor clock divisors of the master clock.
`define SSP_DIV_0 6
`define SSP_DIV_1 12
`define SSP_DIV_2 48
`define SSP_DIV_3 96

`endif

// File: verilog/ssp_sync.v
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
    parameter W = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q_ff
);
    reg [W-1:0] meta_ff;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= {W{1'b0}};
            q_ff <= {W{1'b0}};
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
endmodule // ssp_sync
`default_nettype wire

// File: verilog/ssp_div.v
// Half-period tick generator for the master serial clock.
// Assumes half is at least 1; counting restarts whenever run is low.
`timescale 1ns/1ps
`default_nettype none
module ssp_div (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Control
    input wire run,
    input wire [5:0] half,
    // Tick
    output reg tick_ff
);
    reg [5:0] cnt_ff;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 6'h00;
            tick_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff <= 6'h00;
            tick_ff <= 1'b0;
        end else if (cnt_ff == half - 6'h01) begin
            cnt_ff <= 6'h00;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 6'h01;
            tick_ff <= 1'b0;
        end
    end
endmodule // ssp_div
`default_nettype wire

// File: verilog/ssp_port.v
// Byte-wide serial port, master or slave, with AHB-Lite register access.
// Assumes a single AHB-Lite master; pins are asynchronous and are synchronised here.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.vh"

module ssp_port (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout_ff,
    output reg hresp_ff,
    output reg [31:0] hrdata_ff,
    // Interrupt
    output reg irq_ff,
    // Pins: 0 clock, 1 select, 2 master_out_line, 3 master_in_line
    input wire [3:0] pin_in,
    output reg [3:0] pin_out_ff,
    output reg [3:0] pin_oe_ff
);
    // Registers.
    reg [7:0] cfg_ff;
    reg [7:0] thr_ff;
    reg thr_full_ff;
    reg [7:0] rbuf_ff;
    reg [1:0] sts_ff;
    reg [1:0] msk_ff;
    reg [11:0] pin_ff;
    reg wr_ff;
    reg [7:0] widx_ff;
    // Core state.
    reg [7:0] sh_ff;
    reg samp_ff;
    reg pend_ff;
    reg [3:0] bcnt_ff;
    reg act_ff;
    reg [4:0] ecnt_ff;
    reg sclk_ff;
    reg sclk_prev_ff;
    // Next values.
    reg [7:0] nxt_sh;
    reg nxt_samp;
    reg nxt_pend;
    reg [3:0] nxt_bcnt;
    reg nxt_act;
    reg [4:0] nxt_ecnt;
    reg nxt_sclk;
    reg [7:0] nxt_rbuf;
    reg nxt_thr_full;
    reg ev_txe;
    reg ev_rxf;
    reg [5:0] half;
    reg [31:0] rd_val;
    reg [3:0] nxt_out;
    reg [3:0] nxt_oe;

    wire [3:0] s_in;
    wire tick;

    wire [1:0] mode = cfg_ff[`SSP_CFG_MODE_HI:`SSP_CFG_MODE_LO];
    wire is_m = (mode == `SSP_MODE_MASTER);
    wire is_s = (mode == `SSP_MODE_SLAVE);
    wire en = is_m | is_s;
    wire cpol = cfg_ff[`SSP_CFG_CPOL];
    wire cpha = cfg_ff[`SSP_CFG_CPHA];
    wire lsbf = cfg_ff[`SSP_CFG_LSBF];
    // The end that transmits on the master-out line is the master, unless swapped.
    wire tx_on_mosi = is_m ^ cfg_ff[`SSP_CFG_SWAP];
    wire in_bit = tx_on_mosi ? s_in[3] : s_in[2];
    wire out_bit = lsbf ? sh_ff[0] : sh_ff[7];
    wire [7:0] shifted = lsbf ? {samp_ff, sh_ff[7:1]} : {sh_ff[6:0], samp_ff};
    wire sel_act = is_s & ~s_in[1];
    wire sedge = s_in[0] ^ sclk_prev_ff;
    wire edge_e = is_m ? (act_ff & tick) : (sel_act & act_ff & sedge);
    wire lead = is_m ? (sclk_ff == cpol) : (s_in[0] != cpol);
    wire samp_e = edge_e & (lead ^ cpha);
    wire shift_e = edge_e & ~(lead ^ cpha);
    wire aphase = hsel & htrans[1] & hready;
    // Only word-aligned addresses below 0x400 decode; anything else reads zero and ignores writes.
    wire amap = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    localparam integer half_0 = `SSP_DIV_0 / 2;
    localparam integer half_1 = `SSP_DIV_1 / 2;
    localparam integer half_2 = `SSP_DIV_2 / 2;
    localparam integer half_3 = `SSP_DIV_3 / 2;

    ssp_sync #(.W(4)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(pin_in),
        .q_ff(s_in)
    );

    ssp_div u_div (
        .clk(clk),
        .rst_b(rst_b),
        .run(is_m & act_ff),
        .half(half),
        .tick_ff(tick)
    );

    // Half period of the master clock in processor clocks.
    always @* begin
        case (cfg_ff[`SSP_CFG_RATE_HI:`SSP_CFG_RATE_LO])
            2'h0: half = half_0[5:0];
            2'h1: half = half_1[5:0];
            2'h2: half = half_2[5:0];
            default: half = half_3[5:0];
        endcase
    end

    // Shifter: sample edges capture a bit, shift edges move it in.
    always @* begin
        nxt_sh = sh_ff;
        nxt_samp = samp_ff;
        nxt_pend = pend_ff;
        nxt_bcnt = bcnt_ff;
        nxt_act = act_ff;
        nxt_ecnt = ecnt_ff;
        nxt_sclk = sclk_ff;
        nxt_rbuf = rbuf_ff;
        nxt_thr_full = thr_full_ff;
        ev_txe = 1'b0;
        ev_rxf = 1'b0;
        if (!en || (is_s && !sel_act)) begin
            nxt_act = 1'b0;
            nxt_pend = 1'b0;
            nxt_bcnt = 4'h0;
            nxt_ecnt = 5'h00;
            nxt_sclk = cpol;
        end else if (!act_ff) begin
            nxt_sclk = cpol;
            if (is_s || thr_full_ff) begin
                nxt_act = 1'b1;
                nxt_sh = thr_ff;
                nxt_pend = 1'b0;
                nxt_bcnt = 4'h0;
                nxt_ecnt = 5'h00;
                if (thr_full_ff) begin
                    nxt_thr_full = 1'b0;
                    ev_txe = 1'b1;
                end
            end
        end else begin
            if (is_m && tick) begin
                nxt_sclk = ~sclk_ff;
                nxt_ecnt = ecnt_ff + 5'h01;
                if (ecnt_ff == 5'h0F) begin
                    nxt_act = 1'b0;
                end
            end
            if (samp_e) begin
                nxt_samp = in_bit;
                nxt_pend = 1'b1;
                nxt_bcnt = bcnt_ff + 4'h1;
                if (cpha && bcnt_ff == 4'h7) begin
                    nxt_pend = 1'b0;
                    nxt_rbuf = lsbf ? {in_bit, sh_ff[7:1]} : {sh_ff[6:0], in_bit};
                    ev_rxf = 1'b1;
                    nxt_act = 1'b0;
                end
            end
            if (shift_e && pend_ff) begin
                nxt_sh = shifted;
                nxt_pend = 1'b0;
                if (bcnt_ff == 4'h8) begin
                    nxt_rbuf = shifted;
                    ev_rxf = 1'b1;
                    nxt_act = 1'b0;
                end
            end
        end
    end

    // Pin drive: with the port on, serial-use clock and data pins follow it; the select pin and all other pins follow the gpio bits.
    always @* begin
        nxt_out = pin_ff[`SSP_PIN_OUT_LO+3:`SSP_PIN_OUT_LO];
        nxt_oe = pin_ff[`SSP_PIN_OE_LO+3:`SSP_PIN_OE_LO];
        if (en && pin_ff[`SSP_PIN_USE_LO]) begin
            nxt_out[0] = nxt_sclk;
            nxt_oe[0] = is_m;
        end
        if (en && pin_ff[`SSP_PIN_USE_LO+1]) begin
            nxt_out[1] = pin_ff[`SSP_PIN_OUT_LO+1];
        end
        if (en && pin_ff[`SSP_PIN_USE_LO+2]) begin
            nxt_out[2] = out_bit;
            nxt_oe[2] = tx_on_mosi & (is_m | sel_act);
        end
        if (en && pin_ff[`SSP_PIN_USE_LO+3]) begin
            nxt_out[3] = out_bit;
            nxt_oe[3] = ~tx_on_mosi & (is_m | sel_act);
        end
    end

    // Read data selected in the address phase.
    always @* begin
        rd_val = 32'h00000000;
        case (amap ? haddr[9:2] : 8'hFF)
            `SSP_IDX_DATA: rd_val = {24'h000000, rbuf_ff};
            `SSP_IDX_CFG: rd_val = {24'h000000, cfg_ff};
            `SSP_IDX_STS: rd_val = {28'h0000000, act_ff, thr_full_ff, sts_ff};
            `SSP_IDX_MSK: rd_val = {30'h00000000, msk_ff};
            `SSP_IDX_PIN: rd_val = {16'h0000, s_in, pin_ff};
            default: rd_val = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            hrdata_ff <= 32'h00000000;
            wr_ff <= 1'b0;
            widx_ff <= 8'h00;
        end else begin
            wr_ff <= aphase & hwrite;
            if (aphase) begin
                widx_ff <= amap ? haddr[9:2] : 8'hFF;
            end
            if (aphase && !hwrite) begin
                hrdata_ff <= rd_val;
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= `SSP_RST_CFG;
            thr_ff <= `SSP_RST_DATA;
            thr_full_ff <= 1'b0;
            rbuf_ff <= `SSP_RST_DATA;
            sts_ff <= 2'h0;
            msk_ff <= 2'h0;
            pin_ff <= `SSP_RST_PIN;
            irq_ff <= 1'b0;
        end else begin
            rbuf_ff <= nxt_rbuf;
            thr_full_ff <= nxt_thr_full;
            if (wr_ff && widx_ff == `SSP_IDX_DATA) begin
                thr_ff <= hwdata[7:0];
                thr_full_ff <= 1'b1;
            end
            if (wr_ff && widx_ff == `SSP_IDX_CFG) begin
                cfg_ff <= hwdata[7:0];
            end
            if (wr_ff && widx_ff == `SSP_IDX_MSK) begin
                msk_ff <= hwdata[1:0];
            end
            if (wr_ff && widx_ff == `SSP_IDX_PIN) begin
                pin_ff <= hwdata[11:0];
            end
            // A new event wins over a clear in the same cycle.
            sts_ff <= (sts_ff & ~((wr_ff && widx_ff == `SSP_IDX_STS) ? hwdata[1:0] : 2'h0))
                      | {ev_rxf, ev_txe};
            irq_ff <= |(nxt_sts_mask(sts_ff, wr_ff && widx_ff == `SSP_IDX_STS, hwdata[1:0],
                                     {ev_rxf, ev_txe}) & msk_ff);
        end
    end

    function [1:0] nxt_sts_mask;
        input [1:0] cur;
        input clr_en;
        input [1:0] clr;
        input [1:0] set;
        begin
            nxt_sts_mask = (cur & ~(clr_en ? clr : 2'h0)) | set;
        end
    endfunction

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_ff <= 8'h00;
            samp_ff <= 1'b0;
            pend_ff <= 1'b0;
            bcnt_ff <= 4'h0;
            act_ff <= 1'b0;
            ecnt_ff <= 5'h00;
            sclk_ff <= 1'b0;
            sclk_prev_ff <= 1'b0;
            pin_out_ff <= 4'h0;
            pin_oe_ff <= 4'h0;
        end else begin
            sh_ff <= nxt_sh;
            samp_ff <= nxt_samp;
            pend_ff <= nxt_pend;
            bcnt_ff <= nxt_bcnt;
            act_ff <= nxt_act;
            ecnt_ff <= nxt_ecnt;
            sclk_ff <= nxt_sclk;
            sclk_prev_ff <= s_in[0];
            pin_out_ff <= nxt_out;
            pin_oe_ff <= nxt_oe;
        end
    end
endmodule // ssp_port
`default_nettype wire

// File: tb/ssp_props.sv
// Checker of the serial port, bound to its top ports.
// Assumes single word AHB-Lite transfers and one clock.
`timescale 1ns/1ps
`default_nettype none
module ssp_props (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout_ff,
    input wire hresp_ff,
    input wire [31:0] hrdata_ff,
    // Interrupt and pins
    input wire irq_ff,
    input wire [3:0] pin_out_ff,
    input wire [3:0] pin_oe_ff
);
    reg wr_ff;
    reg sk_ff;
    reg [31:0] wa_ff;
    reg [7:0] cfg_ff;
    reg [3:0] use_ff;
    reg [7:0] q_ff;
    reg [7:0] h_ff;
    wire ms = cfg_ff[5:4] == 2'h1;
    wire sl = cfg_ff[5:4] == 2'h2;
    wire qt = q_ff > 8'h04;
    wire [7:0] half = cfg_ff[1] ? (cfg_ff[0] ? 8'h30 : 8'h18) : (cfg_ff[0] ? 8'h06 : 8'h03);
    // Shadows the configure and pin-use fields from bus writes; counts quiet and clock-level cycles.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ff <= 1'b0;
            sk_ff <= 1'b0;
            wa_ff <= 32'h0;
            cfg_ff <= 8'h00;
            use_ff <= 4'h0;
            q_ff <= 8'h00;
            h_ff <= 8'h00;
        end else begin
            wr_ff <= hsel & htrans[1] & hready & hwrite;
            wa_ff <= haddr;
            sk_ff <= pin_out_ff[0];
            h_ff <= (sk_ff != pin_out_ff[0]) ? 8'h00 : h_ff + {7'h0, h_ff != 8'hFF};
            q_ff <= wr_ff ? 8'h00 : q_ff + {7'h0, q_ff != 8'hFF};
            if (wr_ff && wa_ff == 32'hF4) cfg_ff <= hwdata[7:0];
            if (wr_ff && wa_ff == 32'h108) use_ff <= hwdata[3:0];
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    property p_ready;
        hreadyout_ff && !hresp_ff;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state or error response");
    property p_hold;
        !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_zero;
        s_rd ##0 haddr >= 32'h200 |=> hrdata_ff == 32'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("unmapped read not zero");
    property p_rate;
        ms && use_ff[0] && qt && sk_ff != pin_out_ff[0] |-> h_ff >= half - 8'h01;
    endproperty
    a_rate: assert property (p_rate) else $error("serial clock half period too short");
    property p_moe;
        ms && use_ff[0] && use_ff[2] && use_ff[3] && qt |-> pin_oe_ff[0] && pin_oe_ff[2] != cfg_ff[7]
            && pin_oe_ff[3] == cfg_ff[7];
    endproperty
    a_moe: assert property (p_moe) else $error("master pin directions wrong");
    property p_soe;
        sl && use_ff[0] && qt |-> !pin_oe_ff[0];
    endproperty
    a_soe: assert property (p_soe) else $error("slave drives the clock pin");
    property p_off;
        !ms && !sl && qt |=> $stable(pin_out_ff) && $stable(pin_oe_ff);
    endproperty
    a_off: assert property (p_off) else $error("pins move while disabled");
    property p_irq;
        $fell(irq_ff) |-> q_ff < 8'h04;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt dropped without a write");
endmodule // ssp_props
`default_nettype wire

// File: tb/ssp_peer.sv
// Serial device facing the port's master; shifts MSB first.
// Assumes clock idling low, sampling on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
    // Link
    input wire logic sck,
    input wire logic sel_b,
    input wire logic mosi,
    output logic miso,
    // Received byte
    output logic [7:0] rx
);
    logic [7:0] sh = 8'h00;
    initial rx = 8'h00;
    assign miso = sh[7];
    task automatic load(input logic [7:0] b);
        sh = b;
    endtask
    always @(posedge sck) if (!sel_b) rx <= {rx[6:0], mosi};
    // Past the last bit the line shows a changing pattern.
    always @(negedge sck) if (!sel_b) sh <= {sh[6:0], ~sh[7]};
endmodule // ssp_peer
`default_nettype wire

// File: tb/tb_top.sv
// Bench of the serial port as master against a serial device model.
// Assumes a zero wait bus and registered pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] a_dat = 32'hF0;
    localparam logic [31:0] a_cfg = 32'hF4;
    localparam logic [31:0] a_sts = 32'h100;
    localparam logic [31:0] a_pin = 32'h108;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] seed = 32'h20;
    logic [31:0] rv;
    logic [7:0] d;
    logic [7:0] p;
    logic [7:0] peer_rx;
    logic [7:0] exp_q[$];
    logic [31:0] ra[5] = '{32'hF0, 32'hF4, 32'h100, 32'h104, 32'h200};
    logic l;
    int n;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int dv[4] = '{6, 12, 48, 96};
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq;
    wire logic miso;
    wire logic [31:0] hrdata;
    wire logic [3:0] po;
    wire logic [3:0] poe;
    // Undriven pins 0 to 2 show the inverse of their output bit; undriven pin 3 shows the device's miso.
    wire logic [3:0] pin_in = {poe[3] ? po[3] : miso, po[2:0] ^ ~poe[2:0]};
    ssp_port uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout_ff(hreadyout), .hresp_ff(hresp),
        .hrdata_ff(hrdata), .irq_ff(irq), .pin_in(pin_in), .pin_out_ff(po), .pin_oe_ff(poe));
    ssp_peer peer (.sck(pin_in[0]), .sel_b(pin_in[1]), .mosi(pin_in[2]), .miso(miso), .rx(peer_rx));
    always #20 clk = ~clk;
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] ord(input logic [7:0] b, input logic lsb);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = lsb ? b[7 - i] : b[i];
        return r;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rv = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (ra[i]) rd(ra[i], 32'h0);
        bus(1'b1, a_pin, 32'h32D);
        bus(1'b1, 32'h104, 32'h2);
        for (int r = 0; r < 4; r++) begin
            d = xs();
            p = xs();
            l = r[0];
            exp_q.push_back(ord(p, l));
            bus(1'b1, a_dat, {24'h0, d});
            rd(a_sts, 32'h4);
            bus(1'b1, a_cfg, {24'h0, 1'b0, l, 6'h30});
            rd(a_sts, 32'h4);
            bus(1'b1, a_pin, 32'h30D);
            peer.load(p);
            bus(1'b1, a_cfg, {24'h0, 1'b0, l, 4'h4, r[1:0]});
            while (po[0] !== 1'b1) @(posedge clk);
            n = 0;
            while (po[0] === 1'b1) begin
                @(posedge clk);
                n++;
            end
            chk(n, dv[r] / 2);
            chk(irq, 1'b0);
            while (irq !== 1'b1) @(posedge clk);
            rd(a_dat, {24'h0, exp_q.pop_front()});
            chk(peer_rx, ord(d, l));
            rd(a_sts, 32'h3);
            bus(1'b1, a_sts, 32'h3);
            rd(a_sts, 32'h0);
            chk(irq, 1'b0);
            bus(1'b1, a_pin, 32'h32D);
            bus(1'b1, a_cfg, 32'h0);
            $display("transfer %0d done", r);
        end
        bus(1'b1, a_cfg, 32'h18);
        repeat (4) @(posedge clk);
        chk(po[0], 1'b1);
        bus(1'b1, a_cfg, 32'h20);
        repeat (6) @(posedge clk);
        chk(poe[0], 1'b0);
        $display("polarity and slave done");
        end_sim();
    end
endmodule // tb_top
bind ssp_port ssp_props chk_i (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .hrdata_ff(hrdata_ff), .irq_ff(irq_ff), .pin_out_ff(pin_out_ff), .pin_oe_ff(pin_oe_ff));
`default_nettype wire
